// File: logic/ssc_consts.svh
// Constants for the simultaneous SAR conversion control block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
`define SSC_NCH 4
`define SSC_BITS 16
`define SSC_FIFO_DEPTH 8
`define SSC_ADDR_STATUS 8'h01
`define SSC_ADDR_CTRL 8'h02
`define SSC_ADDR_PWR 8'h03
`define SSC_ADDR_RANGE0 8'h2A
`define SSC_CH_STRIDE 8'h12
`define SSC_FLD_RANGE 8'h00
`define SSC_FLD_OFFSET 8'h01
`define SSC_FLD_GAIN 8'h04
`define SSC_FLD_PHASE 8'h05
`define SSC_RANGE_RST 4'hF
`define SSC_GAIN_RST 16'h8000
`define SSC_GAIN_SHIFT 15
`define SSC_MSB_CODE 16'h8000
`define SSC_BIP_BIAS 19'sh0_8000
`define SSC_BIP_HI 36'sh0_0000_7FFF
`define SSC_BIP_LO 36'shF_FFFF_8000
`define SSC_UNI_HI 36'sh0_0000_FFFF
`define SSC_UNI_LO 36'sh0_0000_0000
`define SSC_PWR_NORMAL 2'h0
`define SSC_PWR_NAP 2'h1
`define SSC_CTRL_OS_EN 8
`endif

// File: logic/ssc_pkg.sv
// Types shared by the conversion control block.
// Assumes the constants header is compiled alongside.
package ssc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ACC, ST_PUSH} ssc_state_type;
  // One result word
  typedef logic [15:0] ssc_word_type;
endpackage : ssc_pkg

// File: logic/ssc_fifo.sv
// Result word buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ssc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Word storage
  logic [AW-1:0] wr_ptr; // Write index
  logic [AW-1:0] rd_ptr; // Read index
  logic [AW:0] count; // Words held
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  // Honest full and empty
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  // Storage write, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
  // Pointers and fill level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssc_fifo

// File: logic/ssc_sar_chan.sv
// One channel: track/hold control and 16-step binary search.
// Assumes the comparator answers for the current trial code each cycle.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_sar_chan (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_delay,
  input wire logic i_comp,
  output logic o_hold,
  output logic [15:0] o_dac,
  output logic o_done,
  output logic [15:0] o_raw
);
  logic [7:0] wait_cnt; // Hold delay remaining
  logic waiting; // Delaying the hold
  logic running; // Search in progress
  logic [15:0] bit_mask; // Weight under trial
  // Hold now, or when the delay runs out
  wire go = i_start ? (i_delay == 8'h00) : (waiting && wait_cnt == 8'h01);
  // Keep the trial bit when input is at or above it
  wire [15:0] next_raw = o_raw | (i_comp ? bit_mask : 16'h0000);
  // Sequencer for one channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_cnt <= 8'h00;
      waiting <= 1'b0;
      running <= 1'b0;
      bit_mask <= 16'h0000;
      o_hold <= 1'b0;
      o_dac <= 16'h0000;
      o_done <= 1'b0;
      o_raw <= 16'h0000;
    end else if (go) begin
      // Track to hold, first trial at half scale
      waiting <= 1'b0;
      running <= 1'b1;
      o_hold <= 1'b1;
      bit_mask <= `SSC_MSB_CODE;
      o_dac <= `SSC_MSB_CODE;
      o_raw <= 16'h0000;
      o_done <= 1'b0;
    end else if (i_start) begin
      // Delayed hold for phase adjustment
      waiting <= 1'b1;
      wait_cnt <= i_delay;
      o_done <= 1'b0;
    end else if (waiting) begin
      wait_cnt <= wait_cnt - 8'h01;
    end else if (running) begin
      // Step down to the next binary weight
      o_raw <= next_raw;
      if (bit_mask[0]) begin
        running <= 1'b0;
        o_hold <= 1'b0;
        o_done <= 1'b1;
      end else begin
        bit_mask <= bit_mask >> 1;
        o_dac <= next_raw | (bit_mask >> 1);
      end
    end
  end
endmodule : ssc_sar_chan

// File: logic/ssc_sar_control.sv
// Top of the four-channel simultaneous SAR conversion control.
// Assumes synchronous pins, one 250 MHz clock and a plain register port.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ssc_consts.svh"

// Functional notes
// - Start edge holds all channels, starts conversion
// - Sixteen-step binary search per channel
// - Words prepared only after all channels finish
// - Full scale split into 2^16 code levels
// - Bipolar twos complement, unipolar straight binary
// - Odd range codes select bipolar spans
// - Even range codes select unipolar spans
// - Each channel keeps its own range code
// - One to four single-ended output lines
// - Strap picks bus; registers on separate port
// - Averaging plus offset, gain; phase adjustment only while averaging is on
// - Nap and power-down idle states
// - Range code resets to fifteen
// - Busy high at start, data before fall
module ssc_sar_control
  import ssc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_conv_start,
  input wire logic i_lvds_strap,
  input wire logic [3:0] i_comp,
  output logic [3:0] o_hold,
  output logic [63:0] o_dac,
  output logic o_busy,
  input wire logic i_sck,
  input wire logic i_cs_n,
  output logic [3:0] o_sdo,
  output logic o_nap,
  output logic o_pdown
);

  // Channel field address match, one bit per channel
  function automatic logic [3:0] ch_hit(input logic [7:0] a, input logic [7:0] f);
    logic [3:0] h;
    h = 4'h0;
    for (int c = 0; c < 4; c++) begin
      h[c] = (a == 8'(`SSC_ADDR_RANGE0 + 8'(c) * `SSC_CH_STRIDE + f));
    end
    return h;
  endfunction : ch_hit

  // Bits driven on the lanes for a shift word
  function automatic logic [3:0] lane_bits(input logic [15:0] sr, input logic [2:0] n);
    logic [3:0] b;
    b = 4'h0;
    for (int k = 0; k < 4; k++) begin
      b[k] = (3'(k) < n) ? sr[15-k] : 1'b0;
    end
    return b;
  endfunction : lane_bits

  // Range code bit 0 marks a bipolar span
  function automatic logic is_bipolar(input logic [3:0] code);
    return code[0];
  endfunction : is_bipolar

  // Per-channel settings
  logic [3:0] range_code [4]; // Span select
  logic [15:0] ofs [4]; // Signed offset
  logic [15:0] gain [4]; // Gain, 0x8000 is unity
  logic [7:0] phase [4]; // Hold delay in cycles

  // Global settings and state
  logic [1:0] lanes_m1; // Output lines minus one
  logic [3:0] os_ratio; // Averages 2^(ratio+1)
  logic os_en; // Averaging on
  logic [1:0] pwr; // Power state
  logic lvds_mode; // Strap latched
  logic strap_taken; // Strap sampled once
  ssc_state_type state; // Sequencer
  logic start_q; // Start pin last cycle
  logic sck_q; // Serial clock last cycle
  logic [16:0] os_cnt; // Conversions in window
  logic [31:0] acc [4]; // Sample sums
  logic [1:0] push_ch; // Channel being output
  logic [15:0] sr; // Serial shift word
  logic [4:0] sent; // Bits shifted so far
  logic ser_busy; // Word on the lanes

  // Channel outputs
  logic [3:0] done;
  logic [15:0] raw [4];

  // Address decodes for writes and reads
  wire [3:0] hit_rng = ch_hit(i_addr, `SSC_FLD_RANGE);
  wire [3:0] hit_ofs = ch_hit(i_addr, `SSC_FLD_OFFSET);
  wire [3:0] hit_gain = ch_hit(i_addr, `SSC_FLD_GAIN);
  wire [3:0] hit_ph = ch_hit(i_addr, `SSC_FLD_PHASE);
  wire hit_ctrl = (i_addr == `SSC_ADDR_CTRL);
  wire hit_pwr = (i_addr == `SSC_ADDR_PWR);
  wire hit_stat = (i_addr == `SSC_ADDR_STATUS);

  // Start handling
  wire start_edge = i_conv_start && !start_q;
  wire powered = !o_nap && !o_pdown; // Registered state, refusal in step with the pins
  // Edges during a conversion or low power are dropped
  wire accept = start_edge && (state == ST_IDLE) && powered;
  wire all_done = &done;
  wire os_first = (os_cnt == 17'h0_0000);
  wire [4:0] os_shift = os_en ? (5'(os_ratio) + 5'h01) : 5'h00;
  wire [16:0] os_last_cnt = (17'h0_0001 << os_shift) - 17'h0_0001; // Five-bit shift, ratio 15 gives 2^16
  wire os_last = !os_en || (os_cnt == os_last_cnt);

  // Correction path for the channel being output
  wire [3:0] cur_rng = range_code[push_ch];
  wire cur_bip = is_bipolar(cur_rng);
  wire [15:0] avg16 = 16'(acc[push_ch] >> os_shift);
  // Raw code spans 2^16 levels from the span bottom
  wire signed [18:0] v_base = $signed({3'b000, avg16});
  wire signed [18:0] v_cent = v_base - (cur_bip ? `SSC_BIP_BIAS : 19'sh0_0000);
  wire signed [18:0] v_ofs = v_cent + 19'($signed(ofs[push_ch]));
  wire signed [35:0] prod = v_ofs * $signed({1'b0, gain[push_ch]});
  wire signed [35:0] scaled = prod >>> `SSC_GAIN_SHIFT;
  wire signed [35:0] lim_hi = cur_bip ? `SSC_BIP_HI : `SSC_UNI_HI;
  wire signed [35:0] lim_lo = cur_bip ? `SSC_BIP_LO : `SSC_UNI_LO;
  // Low bits give twos complement or straight binary
  wire [15:0] out_word = (scaled > lim_hi) ? 16'(lim_hi) :
                         (scaled < lim_lo) ? 16'(lim_lo) : 16'(scaled);

  // Buffer handshake
  wire fifo_in_valid = (state == ST_PUSH);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire load = !ser_busy && fifo_out_valid;

  // Serial side
  wire [2:0] lanes = lvds_mode ? 3'h1 : (3'(lanes_m1) + 3'h1);
  wire sck_rise = i_sck && !sck_q && !i_cs_n;
  wire [4:0] next_sent = sent + 5'(lanes);
  wire [15:0] next_sr = 16'(sr << lanes);

  // Read-back per channel
  logic [15:0] ch_rd [4];
  wire [15:0] stat_word = {11'h000, fifo_out_valid, lvds_mode, o_busy, state};
  wire [15:0] ctrl_word = {7'h00, os_en, os_ratio, 2'h0, lanes_m1};
  wire [15:0] rd_word = (hit_stat ? stat_word : 16'h0000) |
                        (hit_ctrl ? ctrl_word : 16'h0000) |
                        (hit_pwr ? {14'h0000, pwr} : 16'h0000) |
                        ch_rd[0] | ch_rd[1] | ch_rd[2] | ch_rd[3];

  // Per-channel registers and converters
  for (genvar g = 0; g < 4; g++) begin : g_ch
    // Independent settings per channel
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        range_code[g] <= `SSC_RANGE_RST;
        ofs[g] <= 16'h0000;
        gain[g] <= `SSC_GAIN_RST;
        phase[g] <= 8'h00;
      end else if (i_wr) begin
        if (hit_rng[g]) range_code[g] <= i_wdata[3:0];
        if (hit_ofs[g]) ofs[g] <= i_wdata;
        if (hit_gain[g]) gain[g] <= i_wdata;
        if (hit_ph[g]) phase[g] <= i_wdata[7:0];
      end
    end
    // Sums for averaging
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        acc[g] <= 32'h0000_0000;
      end else if (state == ST_ACC) begin
        acc[g] <= os_first ? 32'(raw[g]) : acc[g] + 32'(raw[g]);
      end
    end
    // Register read-back
    assign ch_rd[g] = (hit_rng[g] ? {12'h000, range_code[g]} : 16'h0000) |
                      (hit_ofs[g] ? ofs[g] : 16'h0000) |
                      (hit_gain[g] ? gain[g] : 16'h0000) |
                      (hit_ph[g] ? {8'h00, phase[g]} : 16'h0000);
    // One shared start for every channel
    ssc_sar_chan u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(accept),
      .i_delay(os_en ? phase[g] : 8'h00),
      .i_comp(i_comp[g]),
      .o_hold(o_hold[g]),
      .o_dac(o_dac[g*16 +: 16]),
      .o_done(done[g]),
      .o_raw(raw[g])
    );
  end

  // Global settings
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lanes_m1 <= 2'h0;
      os_ratio <= 4'h0;
      os_en <= 1'b0;
      pwr <= `SSC_PWR_NORMAL;
    end else if (i_wr && hit_ctrl) begin
      lanes_m1 <= i_wdata[1:0];
      os_ratio <= i_wdata[7:4];
      os_en <= i_wdata[`SSC_CTRL_OS_EN];
    end else if (i_wr && hit_pwr) begin
      pwr <= i_wdata[1:0];
    end
  end

  // Bus strap caught once after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvds_mode <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      lvds_mode <= i_lvds_strap;
      strap_taken <= 1'b1;
    end
  end

  // Pin history and power outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      start_q <= 1'b0;
      sck_q <= 1'b0;
      o_nap <= 1'b0;
      o_pdown <= 1'b0;
    end else begin
      start_q <= i_conv_start;
      sck_q <= i_sck;
      o_nap <= (pwr == `SSC_PWR_NAP);
      o_pdown <= pwr[1];
    end
  end

  // Registered read data, valid the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_word : 16'h0000;
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      o_busy <= 1'b0;
      os_cnt <= 17'h0_0000;
      push_ch <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (i_wr && hit_ctrl) begin
            // Fresh averaging window on reconfiguration
            os_cnt <= 17'h0_0000;
          end
          if (accept) begin
            state <= ST_CONV;
            o_busy <= 1'b1;
          end
        end
        ST_CONV: begin
          // Wait for every channel's search
          if (all_done) begin
            state <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (os_last) begin
            state <= ST_PUSH;
            push_ch <= 2'h0;
          end else begin
            // Busy stays high inside the window
            state <= ST_IDLE;
            os_cnt <= os_cnt + 17'h0_0001;
          end
        end
        ST_PUSH: begin
          // One word per channel, stalls when buffer is full
          if (fifo_in_ready) begin
            push_ch <= push_ch + 2'h1;
            if (push_ch == 2'h3) begin
              state <= ST_IDLE;
              o_busy <= 1'b0;
              os_cnt <= 17'h0_0000;
            end
          end
        end
      endcase
    end
  end

  // Result buffer between conversion and serial out
  ssc_fifo #(
    .WIDTH(`SSC_BITS),
    .DEPTH(`SSC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(out_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load),
    .o_out_data(fifo_out_data)
  );

  // Serial shifter, lanes bits per host clock edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sr <= 16'h0000;
      sent <= 5'h00;
      ser_busy <= 1'b0;
      o_sdo <= 4'h0;
    end else if (load) begin
      // Next word onto the lanes, MSB first
      sr <= fifo_out_data;
      sent <= 5'h00;
      ser_busy <= 1'b1;
      o_sdo <= lane_bits(fifo_out_data, lanes);
    end else if (ser_busy && sck_rise) begin
      if (next_sent >= 5'h10) begin
        // Word finished
        ser_busy <= 1'b0;
        o_sdo <= 4'h0;
      end else begin
        sr <= next_sr;
        sent <= next_sent;
        o_sdo <= lane_bits(next_sr, lanes);
      end
    end
  end

endmodule : ssc_sar_control

// File: test/ssc_sar_control_chk.sv
// Port checker of the four-channel conversion control.
// Assumes bind onto the top module, phase delays left at zero.
`timescale 1ns/1ps
module ssc_sar_control_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_conv_start,
  input wire logic [3:0] i_comp,
  input wire logic [3:0] o_hold,
  input wire logic [63:0] o_dac,
  input wire logic o_busy,
  input wire logic o_nap,
  input wire logic o_pdown
);
  // One clock, one reset for every property
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Block ready to take a start edge
  wire logic idle_ok = !o_busy && !o_nap && !o_pdown;
  // Range register addresses
  wire logic rng_adr = i_addr == 8'h2A || i_addr == 8'h3C || i_addr == 8'h4E || i_addr == 8'h60;
  logic [7:0] hold_cnt; // Cycles with every channel held
  // Count the hold run
  always_ff @(posedge i_clk) begin
    if (i_rst || o_hold != 4'hF) begin
      hold_cnt <= 8'h00;
    end else begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end
  start_hold_a:
    assert property ($rose(i_conv_start) && idle_ok && !$past(i_rst) |=>
      o_hold == 4'hF && o_busy && o_dac == 64'h8000_8000_8000_8000) else $error("no hold after start");
  search_len_a:
    assert property ($fell(o_hold[0]) |-> hold_cnt == 8'h10) else $error("search not sixteen steps");
  trial_step_a:
    assert property ($rose(o_busy) |=> o_dac[15] == $past(i_comp[0]) && o_dac[14]
      && o_dac[47] == $past(i_comp[2]) && o_dac[46]) else $error("trial code step wrong");
  busy_len_a:
    assert property ($rose(o_busy) |-> ##21 o_busy ##[1:400] !o_busy) else $error("busy length wrong");
  track_idle_a:
    assert property (!o_busy |-> o_hold == 4'h0) else $error("hold outside conversion");
  rdata_one_a:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not cleared");
  range_width_a:
    assert property (i_rd && rng_adr |=> o_rdata[15:4] == 12'h000) else $error("range wider than four bits");
  unmapped_read_a:
    assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
  low_power_a:
    assert property ((o_nap || o_pdown) && !o_busy |=> !o_busy) else $error("conversion in low power");
  // Main scenarios reached
  cover property ($rose(o_busy));
  cover property (o_nap);
  cover property (o_pdown);
  cover property (o_busy && !o_hold[0] ##1 o_busy && o_hold[0]);
endmodule : ssc_sar_control_chk

// File: test/ssc_front_model.sv
// Analog front model: held inputs and one comparator per channel.
// Assumes trial codes from the control block on a 16-bit scale.
`timescale 1ns/1ps
module ssc_front_model (
  input wire logic i_clk,
  input wire logic [3:0] i_hold,
  input wire logic [63:0] i_dac,
  input wire logic [63:0] i_vin,
  output logic [3:0] o_comp
);
  logic [63:0] held; // Sampled levels
  logic toggle = 1'b0; // Junk answer while tracking
  // Track while not held, freeze on hold
  always_ff @(posedge i_clk) begin
    toggle <= !toggle;
    for (int n = 0; n < 4; n++) begin
      if (!i_hold[n]) begin
        held[16*n +: 16] <= i_vin[16*n +: 16];
      end
    end
  end
  // Held level against the trial code
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      o_comp[n] = i_hold[n] ? held[16*n +: 16] >= i_dac[16*n +: 16] : toggle;
    end
  end
endmodule : ssc_front_model

// File: test/ssc_sar_control_tb.sv
// Testbench of the four-channel conversion control.
// Assumes the front model as comparator and the bench as serial host.
`timescale 1ns/1ps
module ssc_sar_control_tb
  import ssc_pkg::*;
;
  typedef struct packed {logic [15:0] rng; logic [63:0] exp;} ssc_row_type;
  // Range codes per channel beside the words expected
  ssc_row_type rows [4] = '{'{16'h3210, 64'h0001_0000_7FFF_1234}, '{16'h6745, 64'h8001_8000_FFFF_9234},
    '{16'hBA98, 64'h0001_0000_7FFF_1234}, '{16'hEFCD, 64'h8001_8000_FFFF_9234}};
  logic [63:0] vin = 64'h8001_0000_FFFF_1234; // Held levels
  logic [63:0] adj = 64'h0001_8000_3FFF_9244; // Corrected words, all ranges bipolar
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_conv_start = 1'b0;
  logic i_sck = 1'b0, i_cs_n = 1'b0, i_lvds_strap = 1'b0, o_busy, o_nap, o_pdown;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic [3:0] i_comp, o_hold, o_sdo;
  logic [63:0] o_dac;
  int fail_count = 0, tests_run = 0, cycles = 0;
  // Clock at 250 MHz
  always #2 i_clk = ~i_clk;
  ssc_sar_control ssc_sar_control_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_start(i_conv_start), .i_lvds_strap(i_lvds_strap),
    .i_comp(i_comp), .o_hold(o_hold), .o_dac(o_dac), .o_busy(o_busy), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .o_sdo(o_sdo), .o_nap(o_nap), .o_pdown(o_pdown));
  ssc_front_model ssc_front_model_inst (.i_clk(i_clk), .i_hold(o_hold), .i_dac(o_dac), .i_vin(vin),
    .o_comp(i_comp));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask : rd
  // Start edge, optional second edge at a given busy count, count busy cycles
  task automatic convert(input int extra_at, output int bc);
    bc = 0;
    @(posedge i_clk);
    i_conv_start <= 1'b1;
    @(posedge i_clk);
    i_conv_start <= 1'b0;
    #1;
    while (o_busy === 1'b1 && bc < 200) begin
      bc++;
      @(posedge i_clk);
      i_conv_start <= (bc == extra_at);
      #1;
    end
  endtask : convert
  // Shift one word out over the given lane count
  task automatic read_word(input int lanes, output logic [15:0] w);
    w = 16'h0000;
    for (int s = 0; s < 16; s += lanes) begin
      repeat (3) @(posedge i_clk);
      #1;
      for (int k = 0; k < lanes; k++) w[15-s-k] = o_sdo[k];
      @(posedge i_clk);
      i_sck <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sck <= 1'b0;
    end
  endtask : read_word
  initial begin
    logic [15:0] w;
    int bc;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    // Range codes after reset
    for (int n = 0; n < 4; n++) begin
      rd(8'h2A + 8'h12 * 8'(n), w);
      check("range reset", w, 16'h000F);
    end
    // Range keeps four bits, unmapped reads zero
    wr(8'h3C, 16'hFFF5);
    rd(8'h3C, w);
    check("range store", w, 16'h0005);
    rd(8'h00, w);
    check("unmapped", w, 16'h0000);
    // Every range code, channels set apart, one lane
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 4; n++) wr(8'h2A + 8'h12 * 8'(n), {12'h000, rows[r].rng[4*n +: 4]});
      convert(0, bc);
      check("busy cycles", 16'(bc), 16'h0016);
      for (int n = 0; n < 4; n++) begin
        read_word(1, w);
        check("word", w, rows[r].exp[16*n +: 16]);
      end
    end
    // Four lanes, stray start edge, eight words held (seven buffered, one in the shifter) before draining
    wr(8'h02, 16'h0003);
    convert(5, bc);
    check("busy extra edge", 16'(bc), 16'h0016);
    convert(0, bc);
    check("busy second", 16'(bc), 16'h0016);
    for (int n = 0; n < 8; n++) begin
      read_word(4, w);
      check("lane word", w, rows[3].exp[16*(n%4) +: 16]);
    end
    // Nap and power-down refuse starts
    wr(8'h03, 16'h0001);
    @(posedge i_clk);
    #1;
    check("nap", {15'h0000, o_nap}, 16'h0001);
    convert(0, bc);
    check("nap start", 16'(bc), 16'h0000);
    wr(8'h03, 16'h0002);
    @(posedge i_clk);
    #1;
    check("power down", {14'h0000, o_pdown, o_nap}, 16'h0002);
    convert(0, bc);
    check("down start", 16'(bc), 16'h0000);
    // Fresh reset with the strap set: one lane, status shows it
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_lvds_strap <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h01, w);
    check("strap status", w, 16'h0008);
    // Two-sample average, offset, half gain and a saturating offset
    wr(8'h2B, 16'h0010);
    wr(8'h40, 16'h4000);
    wr(8'h4F, 16'hFFFF);
    wr(8'h02, 16'h0103);
    convert(25, bc);
    check("busy window", 16'(bc), 16'h0030);
    for (int n = 0; n < 4; n++) begin
      read_word(1, w);
      check("strap word", w, adj[16*n +: 16]);
    end
    final_report();
  end
endmodule : ssc_sar_control_tb

bind ssc_sar_control ssc_sar_control_chk ssc_sar_control_chk_inst (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_start(i_conv_start), .i_comp(i_comp),
  .o_hold(o_hold), .o_dac(o_dac), .o_busy(o_busy), .o_nap(o_nap), .o_pdown(o_pdown));
